// [tb/tb_window_watchdog_timer.sv]
`timescale 1ns/100ps
module tb_window_watchdog_timer;
  logic        clk_in = 0, reset_n_in = 0, wake = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, dout, q;
  logic        ack, req, irq;
  int          bad_count = 0, tests_run = 0, req_n = 0;
  wwdt_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .wakeup_osc_clock_in(wake), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(dout),
    .wb_ack_out(ack), .reset_req_out(req), .irq_out(irq));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (req === 1'b1) req_n <= req_n + 1;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 50);
    q = dout;
    cyc <= 0; stb <= 0;
    @(posedge clk_in);
    if (n >= 50) begin bad_count++; stop_test(); end
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd
  task automatic t_reset();
    rd("ctrl", 8'h00, 32'h5);
    rd("reload", 8'h08, 32'hff02);
    rd("count", 8'h10, 32'hff02);
    rd("window", 8'h0c, 32'h0);
    rd("status", 8'h14, 32'h0);
    rd("mask", 8'h18, 32'h3);
    rd("cmd", 8'h04, 32'h0);
    rd("unmapped", 8'h1c, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // time from a service to the overflow request with reload all ones
  task automatic t_ovf(input logic [31:0] c, input int n);
    int s, t;
    wb(1, 8'h00, c); wb(1, 8'h08, 32'hffff); wb(1, 8'h14, 32'h3); wb(1, 8'h04, 32'h1);
    s = req_n; t = 0;
    while (req_n == s && t < 40000) begin @(posedge clk_in); t++; end
    chk("ovf_time", 32'(t > n - 6 && t < n + 6), 32'h1);
    if (t >= 40000) stop_test();
    repeat (2) @(posedge clk_in);
    chk("ovf_irq", 32'(irq), 32'h1);
    rd("ovf_status", 8'h14, 32'h1);
    wb(1, 8'h14, 32'h1);
    chk("irq_clear", 32'(irq), 32'h0);
    $display("test overflow %0d done", n);
  endtask : t_ovf
  task automatic t_early();
    int s;
    wb(1, 8'h00, 32'h0); wb(1, 8'h08, 32'hff00); wb(1, 8'h04, 32'h1); wb(1, 8'h0c, 32'hfff0);
    s = req_n;
    wb(1, 8'h04, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("early_req", req_n - s, 32'h1);
    rd("early_status", 8'h14, 32'h2);
    chk("early_irq", 32'(irq), 32'h1);
    wb(1, 8'h14, 32'h2); wb(1, 8'h18, 32'h0); wb(1, 8'h04, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("masked_irq", 32'(irq), 32'h0);
    wb(1, 8'h18, 32'h2);
    @(posedge clk_in);
    chk("unmasked_irq", 32'(irq), 32'h1);
    wb(1, 8'h14, 32'h3); wb(1, 8'h18, 32'h3); wb(1, 8'h0c, 32'h0);
    $display("test early done");
  endtask : t_early
  task automatic t_disable();
    int s;
    logic [31:0] c;
    wb(1, 8'h08, 32'hffff); wb(1, 8'h04, 32'h1);
    s = req_n;
    repeat (200) @(posedge clk_in);
    wb(1, 8'h04, 32'h1);
    repeat (200) @(posedge clk_in);
    chk("serviced_req", req_n - s, 32'h0);
    wb(1, 8'h04, 32'h2);
    rd("ctrl_off", 8'h00, 32'h0);
    wb(0, 8'h10, 32'h0);
    c = q; s = req_n;
    repeat (600) @(posedge clk_in);
    rd("count_held", 8'h10, c);
    chk("off_req", req_n - s, 32'h0);
    wb(1, 8'h04, 32'h6);
    rd("ctrl_on", 8'h00, 32'h4);
    repeat (300) @(posedge clk_in);
    chk("on_req", req_n - s, 32'h1);
    $display("test disable done");
  endtask : t_disable
  task automatic t_wake();
    int s;
    wb(1, 8'h00, 32'h1); wb(1, 8'h04, 32'h1);
    s = req_n;
    for (int i = 0; i < 256; i++) begin
      if (i == 255) chk("wake_early", req_n - s, 32'h0);
      wake <= 1; repeat (2) @(posedge clk_in);
      wake <= 0; repeat (2) @(posedge clk_in);
    end
    repeat (2) @(posedge clk_in);
    chk("wake_req", req_n - s, 32'h1);
    $display("test wakeup done");
  endtask : t_wake
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1;
    @(posedge clk_in);
    t_reset();
    t_ovf(32'h0, 256);
    t_ovf(32'h2, 16384);
    t_early();
    t_disable();
    t_wake();
    stop_test();
  end
endmodule : tb_window_watchdog_timer

// [tb/wwdt_chk.sv]
`timescale 1ns/100ps
module wwdt_chk (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        wakeup_osc_clock_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        reset_req_out,
  input wire logic        irq_out
);
  // enable state as software last commanded it; enable wins a tie
  logic en_q;
  logic rd;
  assign rd = wb_ack_out && !wb_we_in;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= 1'b1;
    end else if (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_adr_in[7:2] == 6'h01 && wb_sel_in[0]) begin
      en_q <= wb_dat_in[2] | (en_q & ~wb_dat_in[1]);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
  ack_timely_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data outside ack");
  cmd_read_a: assert property (rd && wb_adr_in[7:2] == 6'h01 |-> wb_dat_out == 32'h0) else $error("cmd reads nonzero");
  unmapped_a: assert property (rd && wb_adr_in >= 8'h1c |-> wb_dat_out == 32'h0) else $error("unmapped nonzero");
  count_width_a: assert property (rd && wb_adr_in[7:4] == 4'h1 |-> wb_dat_out[31:16] == 16'h0) else $error("wide count");
  req_pulse_a: assert property (reset_req_out |=> !reset_req_out) else $error("request not a pulse");
  req_off_a: assert property (!en_q && !$past(en_q) |-> !reset_req_out) else $error("request while off");
  irq_cause_a: assert property ($rose(irq_out) |-> reset_req_out ||
    $past(wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_adr_in[7:2] == 6'h06))
    else $error("irq without event");
endmodule : wwdt_chk
bind wwdt_top wwdt_chk chk_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .wakeup_osc_clock_in(wakeup_osc_clock_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .reset_req_out(reset_req_out),
  .irq_out(irq_out));

// [verilog/wwdt_pkg.sv]
package wwdt_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_CMD      = 8'h04;
  localparam logic [7:0]  OFF_RELOAD   = 8'h08;
  localparam logic [7:0]  OFF_WINDOW   = 8'h0c;
  localparam logic [7:0]  OFF_COUNT    = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_MASK     = 8'h18;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_CLK_SEL_BIT   = 0;
  localparam int unsigned CTRL_PRESC_SEL_BIT = 1;
  localparam int unsigned CTRL_ENABLED_BIT   = 2;
  localparam int unsigned CMD_SERVICE_BIT    = 0;
  localparam int unsigned CMD_DISABLE_BIT    = 1;
  localparam int unsigned CMD_ENABLE_BIT     = 2;
  localparam int unsigned EVT_OVERFLOW_BIT   = 0;
  localparam int unsigned EVT_EARLY_BIT      = 1;
  localparam int unsigned EVT_W              = 2;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ        = 200_000_000;
  localparam int unsigned WU_FREQ_KHZ        = 500;
  localparam int unsigned DIV_HI             = 16384;
  localparam int unsigned DIV_LO             = 256;
  localparam int unsigned DEFAULT_INTERVAL_US = 130_000;
  localparam int unsigned DEFAULT_WU_TICKS   = DEFAULT_INTERVAL_US * WU_FREQ_KHZ / 1000;
  localparam int unsigned DEFAULT_COUNTS     = (DEFAULT_WU_TICKS + DIV_LO - 1) / DIV_LO;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CNT_W              = 16;
  localparam logic        RST_CLK_SEL        = 1'b1;
  localparam logic        RST_PRESC_SEL      = 1'b0;
  localparam logic        RST_ENABLED        = 1'b1;
  localparam logic [15:0] RST_RELOAD         = 16'(32'h0001_0000 - DEFAULT_COUNTS);
  localparam logic [15:0] RST_WINDOW         = 16'h0000;
  localparam logic [1:0]  RST_MASK           = 2'h3;

endpackage : wwdt_pkg

// [verilog/wwdt_prescaler.sv]
`timescale 1ns/100ps
module wwdt_prescaler #(
  parameter int unsigned DIV_HI = wwdt_pkg::DIV_HI,
  parameter int unsigned DIV_LO = wwdt_pkg::DIV_LO
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // control
  input  wire logic enable_in,
  input  wire logic clear_in,
  input  wire logic sel_hi_in,
  input  wire logic src_tick_in,
  // output
  output logic      tick_out
);

  localparam int unsigned PW = $clog2(DIV_HI);
  localparam logic [PW-1:0] LAST_HI = PW'(DIV_HI - 1);
  localparam logic [PW-1:0] LAST_LO = PW'(DIV_LO - 1);

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic          tick;
  } wwdt_presc_state_type;

  wwdt_presc_state_type state_q;
  wwdt_presc_state_type state_d;

  always_comb begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (clear_in || !enable_in) begin
      state_d.cnt = '0;
    end else if (src_tick_in) begin
      // at or past the end, so a switch to the short ratio never runs the long way round
      if (state_q.cnt >= (sel_hi_in ? LAST_HI : LAST_LO)) begin
        state_d.cnt  = '0;
        state_d.tick = 1'b1;
      end else begin
        state_d.cnt = state_q.cnt + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tick_out = state_q.tick;

endmodule : wwdt_prescaler

// [verilog/wwdt_top.sv]
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module wwdt_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // wakeup oscillator clock, sampled as a level
  input  wire logic        wakeup_osc_clock_in,
  // wishbone classic slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // system side
  output logic             reset_req_out,
  output logic             irq_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                        clk_sel;
    logic                        presc_sel;
    logic                        enabled;
    logic [15:0]                 reload;
    logic [15:0]                 window;
    logic [15:0]                 count;
    logic [wwdt_pkg::EVT_W-1:0]  status;
    logic [wwdt_pkg::EVT_W-1:0]  mask;
    logic                        wu_prev;
    logic                        ack;
    logic [31:0]                 rdata;
    logic                        irq;
    logic                        rst_req;
  } wwdt_state_type;

  wwdt_state_type state_q;
  wwdt_state_type state_d;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] wwdt_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : wwdt_merge

  // word compare; the two low address bits never select a register
  function automatic logic wwdt_word_is(input logic [7:0] adr,
                                        input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction : wwdt_word_is

  // control word as software reads it back
  function automatic logic [31:0] wwdt_ctrl_word(input logic clk_sel,
                                                 input logic presc_sel,
                                                 input logic enabled);
    logic [31:0] res;
    res                               = '0;
    res[wwdt_pkg::CTRL_CLK_SEL_BIT]   = clk_sel;
    res[wwdt_pkg::CTRL_PRESC_SEL_BIT] = presc_sel;
    res[wwdt_pkg::CTRL_ENABLED_BIT]   = enabled;
    return res;
  endfunction : wwdt_ctrl_word

  // sticky events: a new event wins over a write-one-to-clear in the same cycle
  function automatic logic [wwdt_pkg::EVT_W-1:0] wwdt_events(input logic [wwdt_pkg::EVT_W-1:0] old_v,
                                                             input logic [wwdt_pkg::EVT_W-1:0] clr,
                                                             input logic                       ovf,
                                                             input logic                       early);
    logic [wwdt_pkg::EVT_W-1:0] res;
    res = old_v & ~clr;
    if (ovf) begin
      res[wwdt_pkg::EVT_OVERFLOW_BIT] = 1'b1;
    end
    if (early) begin
      res[wwdt_pkg::EVT_EARLY_BIT] = 1'b1;
    end
    return res;
  endfunction : wwdt_events

  // read data for one word; unmapped and write-only words read as zero
  function automatic logic [31:0] wwdt_read_mux(input logic [7:0]                 adr,
                                                input logic [31:0]                ctrl,
                                                input logic [15:0]                reload,
                                                input logic [15:0]                window,
                                                input logic [15:0]                count,
                                                input logic [wwdt_pkg::EVT_W-1:0] status,
                                                input logic [wwdt_pkg::EVT_W-1:0] mask);
    logic [31:0] res;
    res = '0;
    unique case (adr)
      wwdt_pkg::OFF_CTRL:   res = ctrl;
      wwdt_pkg::OFF_RELOAD: res[15:0] = reload;
      wwdt_pkg::OFF_WINDOW: res[15:0] = window;
      wwdt_pkg::OFF_COUNT:  res[15:0] = count;
      wwdt_pkg::OFF_STATUS: res[wwdt_pkg::EVT_W-1:0] = status;
      wwdt_pkg::OFF_MASK:   res[wwdt_pkg::EVT_W-1:0] = mask;
      default:              res = '0;
    endcase
    return res;
  endfunction : wwdt_read_mux

  // ---------------------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------------------
  // the selected source only gates the prescaler; everything runs on clk_in
  logic presc_tick;
  logic presc_clear;
  logic src_tick;
  logic wu_edge;

  wwdt_prescaler #(
    .DIV_HI (wwdt_pkg::DIV_HI),
    .DIV_LO (wwdt_pkg::DIV_LO)
  ) u_presc (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .enable_in   (state_q.enabled),
    .clear_in    (presc_clear),
    .sel_hi_in   (state_q.presc_sel),
    .src_tick_in (src_tick),
    .tick_out    (presc_tick)
  );

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  word_adr;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        wr_reload;
  logic        wr_window;
  logic        wr_status;
  logic        wr_mask;
  logic        service_req;
  logic        service_ok;
  logic        service_early;
  logic        overflow;
  logic        cmd_disable;
  logic        cmd_enable;
  logic [31:0] ctrl_img;
  logic [31:0] merged;
  logic [wwdt_pkg::EVT_W-1:0] status_clr;

  always_comb begin
    word_adr      = {wb_adr_in[7:2], 2'b00};
    // one access per request; the idle cycle after ack keeps a held stb from repeating
    access        = wb_cyc_in && wb_stb_in && !state_q.ack;
    wr            = access && wb_we_in;
    rd            = access && !wb_we_in;
    wr_ctrl       = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_CTRL);
    wr_cmd        = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_CMD) && wb_sel_in[0];
    wr_reload     = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_RELOAD);
    wr_window     = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_WINDOW);
    wr_status     = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_STATUS);
    wr_mask       = wr && wwdt_word_is(wb_adr_in, wwdt_pkg::OFF_MASK);
    service_req   = wr_cmd && wb_dat_in[wwdt_pkg::CMD_SERVICE_BIT];
    cmd_disable   = wr_cmd && wb_dat_in[wwdt_pkg::CMD_DISABLE_BIT];
    cmd_enable    = wr_cmd && wb_dat_in[wwdt_pkg::CMD_ENABLE_BIT];
    // inside the window the count is still below the threshold
    service_early = service_req && state_q.enabled && (state_q.count < state_q.window);
    service_ok    = service_req && !service_early;
    overflow      = state_q.enabled && presc_tick && (state_q.count == 16'hffff);
    // a wakeup level shorter than one clock is lost; the source is far slower than clk_in
    wu_edge       = wakeup_osc_clock_in && !state_q.wu_prev;
    src_tick      = state_q.clk_sel ? wu_edge : 1'b1;
    // restarting the prescaler keeps the first interval after a reload full length
    presc_clear   = service_ok || overflow;
    ctrl_img      = wwdt_ctrl_word(state_q.clk_sel, state_q.presc_sel, state_q.enabled);
    status_clr    = (wr_status && wb_sel_in[0]) ? wb_dat_in[wwdt_pkg::EVT_W-1:0] : '0;
    // only one of reload and window is addressed at a time, so one merged image serves both
    merged        = wwdt_merge({16'h0000, wr_window ? state_q.window : state_q.reload}, wb_dat_in, wb_sel_in);
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d         = state_q;
    state_d.ack     = access;
    state_d.rst_req = 1'b0;
    state_d.wu_prev = wakeup_osc_clock_in;

    // ------------------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------------------
    if (wr_ctrl && wb_sel_in[0]) begin
      state_d.clk_sel   = wb_dat_in[wwdt_pkg::CTRL_CLK_SEL_BIT];
      state_d.presc_sel = wb_dat_in[wwdt_pkg::CTRL_PRESC_SEL_BIT];
    end
    if (wr_reload) begin
      state_d.reload = merged[15:0];
    end
    if (wr_window) begin
      state_d.window = merged[15:0];
    end
    // mask bits are written as a pair; lane 0 carries both
    if (wr_mask && wb_sel_in[0]) begin
      state_d.mask = wb_dat_in[wwdt_pkg::EVT_W-1:0];
    end

    // ------------------------------------------------------------------------
    // commands
    // ------------------------------------------------------------------------
    // enable wins when both are given, failing safe
    if (cmd_disable) begin
      state_d.enabled = 1'b0;
    end
    if (cmd_enable) begin
      state_d.enabled = 1'b1;
    end

    // ------------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------------
    // the counter keeps running after an overflow, starting over from the reload value
    if (service_ok || overflow) begin
      state_d.count = state_q.reload;
    end else if (state_q.enabled && presc_tick) begin
      state_d.count = state_q.count + 16'h0001;
    end

    // ------------------------------------------------------------------------
    // reset request on overflow or early service
    // ------------------------------------------------------------------------
    if (overflow || service_early) begin
      state_d.rst_req = 1'b1;
    end

    // ------------------------------------------------------------------------
    // sticky events
    // ------------------------------------------------------------------------
    state_d.status = wwdt_events(state_q.status, status_clr, overflow, service_early);

    // ------------------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------------------
    // taken from the next status, so the level is registered together with it
    state_d.irq = |(state_d.status & state_d.mask);

    // ------------------------------------------------------------------------
    // read data, zero for writes and unmapped words
    // ------------------------------------------------------------------------
    state_d.rdata = rd ? wwdt_read_mux(word_adr, ctrl_img, state_q.reload, state_q.window, state_q.count,
                                       state_q.status, state_q.mask) : '0;
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q           <= '0;
      state_q.clk_sel   <= wwdt_pkg::RST_CLK_SEL;
      state_q.presc_sel <= wwdt_pkg::RST_PRESC_SEL;
      state_q.enabled   <= wwdt_pkg::RST_ENABLED;
      state_q.reload    <= wwdt_pkg::RST_RELOAD;
      // the count starts at the reload value so the first interval is a full one
      state_q.count     <= wwdt_pkg::RST_RELOAD;
      state_q.window    <= wwdt_pkg::RST_WINDOW;
      state_q.mask      <= wwdt_pkg::RST_MASK;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // every output is a register, so nothing combinational leaves the block
  assign wb_dat_out    = state_q.rdata;
  assign wb_ack_out    = state_q.ack;
  assign reset_req_out = state_q.rst_req;
  assign irq_out       = state_q.irq;

endmodule : wwdt_top
